// [dac_model.sv]
/* Converter-side model: sees the code and done strobes, reports each new code
   with its spacing in core cycles, and each done pulse with its width.
   Assumes one core clock and the active low reset. */
`timescale 1ns/1ps
module dac_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] code,
   input wire logic done1,
   input wire logic done2,
   output logic changed,
   output logic [7:0] value,
   output logic [15:0] gap,
   output logic pulse_end,
   output logic done2_end,
   output logic [7:0] width
);
   logic [7:0] last;
   logic [15:0] cnt;
   logic [7:0] run;
   logic was2;
   // a code that differs from the last one is a new sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         changed <= 1'b0;
         value <= 8'h00;
         last <= 8'h00;
         gap <= 16'h0000;
         cnt <= 16'h0000;
      end else begin
         changed <= (code !== last);
         value <= code;
         last <= code;
         cnt <= (code !== last) ? 16'h0001 : cnt + 16'h0001;
         if (code !== last) begin
            gap <= cnt;
         end
      end
   end
   // width of each done pulse, reported once it falls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 8'h00;
         was2 <= 1'b0;
         pulse_end <= 1'b0;
         done2_end <= 1'b0;
         width <= 8'h00;
      end else begin
         pulse_end <= 1'b0;
         if (done1 | done2) begin
            run <= run + 8'h01;
            was2 <= done2;
         end else if (run != 8'h00) begin
            pulse_end <= 1'b1;
            done2_end <= was2;
            width <= run;
            run <= 8'h00;
         end
      end
   end
endmodule

// [pin_sync.sv]
/*
 * Three-stage synchroniser for one asynchronous pin.
 * Output changes only once the second and third stages agree.
 */
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   output logic level
);
   logic ff1, ff2, ff3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
         level <= 1'b0;
      end else if (ce) begin
         ff1 <= pin;
         ff2 <= ff1;
         ff3 <= ff2;
         if (ff2 == ff3) begin
            level <= ff3;
         end
      end
   end
endmodule

// [table_channel.sv]
/*
 * One waveform channel: sample table in flip-flops and its play index.
 * Assumes len is between 1 and the table depth and start is below len.
 */
`timescale 1ns/1ps
module table_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic trig,
   input wire logic restart,
   input wire logic [11:0] len,
   input wire logic [11:0] start,
   input wire logic wr_en,
   input wire logic [11:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [11:0] rd_idx,
   output logic [7:0] rd_data,
   output logic [7:0] sample,
   output logic last,
   output logic [11:0] idx
);
   logic [7:0] mem [0:wave_seq_pkg::DEPTH-1];
   logic at_end;

   assign at_end = (idx == 12'(len - 12'h001));
   assign rd_data = (rd_idx < wave_seq_pkg::LEN_MAX) ? mem[rd_idx] : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < wave_seq_pkg::DEPTH; i++) begin
            mem[i] <= 8'h00;
         end
      end else if (ce && wr_en && wr_idx < wave_seq_pkg::LEN_MAX) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx <= 12'h000;
         sample <= 8'h00;
         last <= 1'b0;
      end else if (ce) begin
         last <= 1'b0;
         if (restart) begin
            idx <= start;
         end else if (trig) begin
            sample <= mem[idx];
            last <= at_end;
            idx <= at_end ? 12'h000 : 12'(idx + 12'h001);
         end
      end
   end

   property p_wrap;
      @(posedge clk) disable iff (!rst_n || !ce)
      trig && !restart && at_end |=> idx == 12'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("index did not wrap to 0");

   property p_step;
      @(posedge clk) disable iff (!rst_n || !ce)
      trig && !restart && !at_end |=> idx == 12'($past(idx) + 12'h001) && last == 1'b0;
   endproperty
   a_step: assert property (p_step) else $error("index did not advance by one");

   property p_hold;
      @(posedge clk) disable iff (!rst_n || !ce)
      !trig && !restart |=> $stable(idx) && $stable(sample);
   endproperty
   a_hold: assert property (p_hold) else $error("channel moved without a trigger");
endmodule

// [test_wave_sequencer.sv]
/* Self-checking bench for the sequencer: registers over AXI4-Lite, sample
   order, spacing, done pulses, interrupt. Assumes the converter model file. */
`timescale 1ns/1ps
module test_wave_sequencer;
   logic CORE_CLK = 1'b0, RESET_N = 1'b0, CLK_EN = 1'b1, WAVEFORM_SELECT = 1'b0;
   logic EXT_SAMPLE_CLK = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b1;
   logic ARVALID = 1'b0, RREADY = 1'b1;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic [3:0] WSTRB = 4'hf;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WAVE1_DONE, WAVE2_DONE, IRQ;
   logic [1:0] BRESP, RRESP, r;
   logic [31:0] RDATA, v;
   logic [7:0] DAC_CODE, value, width;
   logic [15:0] gap, exp_gap;
   logic changed, pulse_end, done2_end, fresh, ext_on = 1'b0;
   logic [7:0] tbl1 [5];
   logic [7:0] tbl2 [3];
   logic [7:0] exp_q [$];
   int failures = 0, compares = 0, cycles = 0, done1_n = 0, done2_n = 0;
   wave_sequencer wave_sequencer_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
      .CLK_EN(CLK_EN), .WAVEFORM_SELECT(WAVEFORM_SELECT), .EXT_SAMPLE_CLK(EXT_SAMPLE_CLK),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .DAC_CODE(DAC_CODE), .WAVE1_DONE(WAVE1_DONE),
      .WAVE2_DONE(WAVE2_DONE), .IRQ(IRQ));
   dac_model dac_model_inst (.clk(CORE_CLK), .rst_n(RESET_N), .code(DAC_CODE),
      .done1(WAVE1_DONE), .done2(WAVE2_DONE), .changed(changed), .value(value), .gap(gap),
      .pulse_end(pulse_end), .done2_end(done2_end), .width(width));
   initial begin
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= d;
      WVALID <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge CORE_CLK);
         if (AWVALID && AWREADY === 1'b1) begin
            AWVALID <= 1'b0;
            aw_ok = 1'b1;
         end
         if (WVALID && WREADY === 1'b1) begin
            WVALID <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do @(posedge CORE_CLK); while (BVALID !== 1'b1);
      r = BRESP;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
      ARADDR <= a;
      ARVALID <= 1'b1;
      do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1) @(posedge CORE_CLK);
      d = RDATA;
      rr = RRESP;
   endtask
   task automatic play(input logic [31:0] ctrl, input logic [15:0] g);
      exp_gap = g;
      fresh = 1'b1;
      wr(wave_seq_pkg::OFS_CTRL, ctrl);
      for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge CORE_CLK);
      // samples that never came count as a mismatch
      check(32'(exp_q.size()), 32'h0);
      exp_q.delete();
      wr(wave_seq_pkg::OFS_CTRL, 32'h0);
   endtask
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         print_verdict();
      end
   end
   // external sample clock, four cycles high and four low
   always @(posedge CORE_CLK) begin
      if (ext_on && cycles % 4 == 0) EXT_SAMPLE_CLK <= ~EXT_SAMPLE_CLK;
   end
   always @(posedge CORE_CLK) begin
      if (changed === 1'b1 && exp_q.size() > 0) begin
         check(32'(value), 32'(exp_q.pop_front()));
         if (!fresh) check(32'(gap), 32'(exp_gap));
         fresh = 1'b0;
      end
      if (pulse_end === 1'b1) begin
         check(32'(width), 32'h2);
         if (done2_end) done2_n++;
         else done1_n++;
      end
   end
   initial begin
      repeat (12) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      void'($urandom(46));
      rd(wave_seq_pkg::OFS_LEN2, v, r);
      check(v, 32'h64);
      rd(wave_seq_pkg::OFS_DIV, v, r);
      check(v, 32'h18f);
      rd(8'h2c, v, r);
      check(32'(r), 32'(wave_seq_pkg::RESP_SLVERR));
      wr(8'h2c, 32'h0);
      check(32'(r), 32'(wave_seq_pkg::RESP_SLVERR));
      wr(wave_seq_pkg::OFS_LEN1, 32'hfff);
      check(32'(r), 32'(wave_seq_pkg::RESP_OKAY));
      rd(wave_seq_pkg::OFS_LEN1, v, r);
      check(v, 32'hfa0);
      for (int k = 0; k < 6; k++) begin
         wr(wave_seq_pkg::OFS_CTRL, 32'(k) << 4 | 32'(5 - k) << 8);
         rd(wave_seq_pkg::OFS_CTRL, v, r);
         check(v, 32'(k) << 4 | 32'(5 - k) << 8);
      end
      wr(wave_seq_pkg::OFS_TADDR, 32'h0);
      for (int i = 0; i < 5; i++) begin
         // never zero, so the first sample differs from the reset code
         tbl1[i] = {1'b0, 3'(i + 1), 4'($urandom)};
         wr(wave_seq_pkg::OFS_TDATA, 32'(tbl1[i]));
      end
      wr(wave_seq_pkg::OFS_TADDR, 32'h1000);
      for (int i = 0; i < 3; i++) begin
         tbl2[i] = {1'b1, 3'(i), 4'($urandom)};
         wr(wave_seq_pkg::OFS_TDATA, 32'(tbl2[i]));
      end
      wr(wave_seq_pkg::OFS_TADDR, 32'h2);
      rd(wave_seq_pkg::OFS_TDATA, v, r);
      check(v, 32'(tbl1[2]));
      wr(wave_seq_pkg::OFS_LEN1, 32'h5);
      wr(wave_seq_pkg::OFS_LEN2, 32'h3);
      wr(wave_seq_pkg::OFS_DIV, 32'h6);
      wr(wave_seq_pkg::OFS_MASK, 32'h1);
      // pin toggles from here on, ignored while the divider is the source
      ext_on <= 1'b1;
      for (int i = 0; i < 7; i++) exp_q.push_back(tbl1[i % 5]);
      play(32'h1, 16'h7);
      check(32'(done1_n > 0), 32'h1);
      check(32'(done2_n), 32'h0);
      WAVEFORM_SELECT <= 1'b1;
      repeat (10) @(posedge CORE_CLK);
      for (int i = 0; i < 7; i++) exp_q.push_back(tbl2[i % 3]);
      play(32'h1, 16'h7);
      check(32'(done2_n > 0), 32'h1);
      repeat (4) @(posedge CORE_CLK);
      check(32'(IRQ), 32'h1);
      wr(wave_seq_pkg::OFS_STAT, 32'h1);
      repeat (3) @(posedge CORE_CLK);
      check(32'(IRQ), 32'h0);
      rd(wave_seq_pkg::OFS_STAT, v, r);
      check(v, 32'h2);
      wr(wave_seq_pkg::OFS_MASK, 32'h3);
      repeat (3) @(posedge CORE_CLK);
      check(32'(IRQ), 32'h1);
      wr(wave_seq_pkg::OFS_STAT, 32'h2);
      repeat (3) @(posedge CORE_CLK);
      check(32'(IRQ), 32'h0);
      WAVEFORM_SELECT <= 1'b0;
      wr(wave_seq_pkg::OFS_PH1, 32'hb4);
      for (int i = 2; i < 8; i++) exp_q.push_back(tbl1[i % 5]);
      play(32'h3, 16'h8);
      print_verdict();
   end
endmodule

// [wave_seq_pkg.sv]
/*
 * Constants, register map and types shared by the waveform sample sequencer.
 * Assumes a single core clock at the rate given here.
 */
package wave_seq_pkg;
   localparam int CLK_HZ = 40_000_000;
   // default sample rate in kSPS
   localparam int RATE_KSPS = 100;
   localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / (RATE_KSPS * 1000) - 1);
   localparam logic [15:0] DIV_MIN = 16'h0001;
   localparam logic [11:0] LEN_MAX = 12'hfa0;
   localparam int DEPTH = int'(LEN_MAX);
   localparam logic [11:0] LEN_RESET = 12'h064;
   localparam logic [8:0] PHASE_RESET = 9'h000;
   // 65536 / 360, degrees to fraction of a period
   localparam logic [7:0] PHASE_SCALE = 8'hb6;
   localparam int PHASE_SHIFT = 16;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIV = 8'h04;
   localparam logic [7:0] OFS_LEN1 = 8'h08;
   localparam logic [7:0] OFS_LEN2 = 8'h0c;
   localparam logic [7:0] OFS_PH1 = 8'h10;
   localparam logic [7:0] OFS_PH2 = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1c;
   localparam logic [7:0] OFS_STATE = 8'h20;
   localparam logic [7:0] OFS_TADDR = 8'h24;
   localparam logic [7:0] OFS_TDATA = 8'h28;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_EXT_BIT = 1;
   localparam int TADDR_SEL_BIT = 12;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      KIND_SINE,
      KIND_SQUARE,
      KIND_TRIANGLE,
      KIND_SAWTOOTH,
      KIND_ARB_DRAW,
      KIND_ARB_FILE
   } wave_kind_t;
endpackage

// [wave_sequencer.sv]
/*
 * Dual waveform sample sequencer with an AXI4-Lite register slave.
 * Assumes WAVEFORM_SELECT and EXT_SAMPLE_CLK are asynchronous pins and
 * that the bus master follows AXI4-Lite handshaking.
 */
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wave_sequencer (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic WAVEFORM_SELECT,
   input wire logic EXT_SAMPLE_CLK,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic [7:0] DAC_CODE,
   output logic WAVE1_DONE,
   output logic WAVE2_DONE,
   output logic IRQ
);
   logic sel_stable, ext_stable, ext_prev, sel_q, trig_q, src_q;
   logic enable, ext_mode, restart1, restart2, tick;
   wave_seq_pkg::wave_kind_t kind1, kind2;
   logic [15:0] divider, div_cnt;
   logic [11:0] len1, len2, idx1, idx2;
   logic [8:0] phase1, phase2;
   logic [1:0] status, mask;
   logic [12:0] taddr;
   logic aw_full, w_full, wr_fire, trig1, trig2, tw1, tw2;
   logic last1, last2, last1_d, last2_d;
   logic [7:0] wr_addr, smp1, smp2, rd1, rd2, tbl_rd;
   logic [31:0] wr_data, wr_word;
   logic [3:0] wr_strb;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= wave_seq_pkg::OFS_TDATA);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // length clamped to 1..table depth
   function automatic logic [11:0] clamp_len(input logic [11:0] v);
      if (v == 12'h000) begin
         clamp_len = 12'h001;
      end else if (v > wave_seq_pkg::LEN_MAX) begin
         clamp_len = wave_seq_pkg::LEN_MAX;
      end else begin
         clamp_len = v;
      end
   endfunction

   // degrees to start sample, fraction of the period
   function automatic logic [11:0] phase_index(input logic [8:0] deg, input logic [11:0] len);
      logic [28:0] p;
      logic [11:0] i;
      p = 29'(deg) * 29'(len) * 29'(wave_seq_pkg::PHASE_SCALE);
      i = p[wave_seq_pkg::PHASE_SHIFT +: 12];
      phase_index = (i >= len) ? 12'h000 : i;
   endfunction

   function automatic logic [31:0] reg_word(input logic [7:0] a);
      case (a)
         wave_seq_pkg::OFS_CTRL: reg_word = {21'h0, kind2, 1'b0, kind1, 2'h0, ext_mode, enable};
         wave_seq_pkg::OFS_DIV: reg_word = {16'h0, divider};
         wave_seq_pkg::OFS_LEN1: reg_word = {20'h0, len1};
         wave_seq_pkg::OFS_LEN2: reg_word = {20'h0, len2};
         wave_seq_pkg::OFS_PH1: reg_word = {23'h0, phase1};
         wave_seq_pkg::OFS_PH2: reg_word = {23'h0, phase2};
         wave_seq_pkg::OFS_STAT: reg_word = {30'h0, status};
         wave_seq_pkg::OFS_MASK: reg_word = {30'h0, mask};
         wave_seq_pkg::OFS_STATE: reg_word = {7'h0, sel_q, DAC_CODE, 4'h0, sel_q ? idx2 : idx1};
         wave_seq_pkg::OFS_TADDR: reg_word = {19'h0, taddr};
         wave_seq_pkg::OFS_TDATA: reg_word = {24'h0, tbl_rd};
         default: reg_word = 32'h0000_0000;
      endcase
   endfunction

   pin_sync u_sel_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .pin(WAVEFORM_SELECT),
      .level(sel_stable)
   );

   pin_sync u_ext_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .pin(EXT_SAMPLE_CLK),
      .level(ext_stable)
   );

   assign wr_fire = aw_full && w_full && !BVALID;
   assign wr_word = merge(reg_word(wr_addr), wr_data, wr_strb);
   assign tbl_rd = taddr[wave_seq_pkg::TADDR_SEL_BIT] ? rd2 : rd1;
   // raw table bytes, any of the six kinds, amplitude and offset baked in
   assign tw1 = wr_fire && wr_addr == wave_seq_pkg::OFS_TDATA && wr_strb[0] &&
                !taddr[wave_seq_pkg::TADDR_SEL_BIT];
   assign tw2 = wr_fire && wr_addr == wave_seq_pkg::OFS_TDATA && wr_strb[0] &&
                taddr[wave_seq_pkg::TADDR_SEL_BIT];
   assign trig1 = trig_q && !sel_q;
   assign trig2 = trig_q && sel_q;

   // write channel: address and data taken in either order
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= wave_seq_pkg::RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (CLK_EN) begin
         if (AWVALID && AWREADY) begin
            wr_addr <= AWADDR;
            aw_full <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY) begin
            wr_data <= WDATA;
            wr_strb <= WSTRB;
            w_full <= 1'b1;
            WREADY <= 1'b0;
         end
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= mapped(wr_addr) ? wave_seq_pkg::RESP_OKAY : wave_seq_pkg::RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= wave_seq_pkg::RESP_OKAY;
      end else if (CLK_EN) begin
         if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= reg_word(ARADDR);
            RRESP <= mapped(ARADDR) ? wave_seq_pkg::RESP_OKAY : wave_seq_pkg::RESP_SLVERR;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         enable <= 1'b0;
         ext_mode <= 1'b0;
         kind1 <= wave_seq_pkg::KIND_SINE;
         kind2 <= wave_seq_pkg::KIND_SINE;
         divider <= wave_seq_pkg::DIV_RESET;
         len1 <= wave_seq_pkg::LEN_RESET;
         len2 <= wave_seq_pkg::LEN_RESET;
         phase1 <= wave_seq_pkg::PHASE_RESET;
         phase2 <= wave_seq_pkg::PHASE_RESET;
         mask <= 2'h0;
         taddr <= 13'h0000;
         restart1 <= 1'b0;
         restart2 <= 1'b0;
      end else if (CLK_EN) begin
         restart1 <= 1'b0;
         restart2 <= 1'b0;
         if (wr_fire) begin
            case (wr_addr)
               wave_seq_pkg::OFS_CTRL: begin
                  enable <= wr_word[wave_seq_pkg::CTRL_EN_BIT];
                  ext_mode <= wr_word[wave_seq_pkg::CTRL_EXT_BIT];
                  kind1 <= wave_seq_pkg::wave_kind_t'(wr_word[6:4]);
                  kind2 <= wave_seq_pkg::wave_kind_t'(wr_word[10:8]);
                  if (wr_word[wave_seq_pkg::CTRL_EN_BIT] && !enable) begin
                     restart1 <= 1'b1;
                     restart2 <= 1'b1;
                  end
               end
               wave_seq_pkg::OFS_DIV: begin
                  divider <= (wr_word[15:0] < wave_seq_pkg::DIV_MIN) ?
                             wave_seq_pkg::DIV_MIN : wr_word[15:0];
               end
               wave_seq_pkg::OFS_LEN1: begin
                  len1 <= clamp_len(wr_word[11:0]);
                  restart1 <= 1'b1;
               end
               wave_seq_pkg::OFS_LEN2: begin
                  len2 <= clamp_len(wr_word[11:0]);
                  restart2 <= 1'b1;
               end
               wave_seq_pkg::OFS_PH1: begin
                  phase1 <= wr_word[8:0];
                  restart1 <= 1'b1;
               end
               wave_seq_pkg::OFS_PH2: begin
                  phase2 <= wr_word[8:0];
                  restart2 <= 1'b1;
               end
               wave_seq_pkg::OFS_MASK: mask <= wr_word[1:0];
               wave_seq_pkg::OFS_TADDR: taddr <= wr_word[12:0];
               wave_seq_pkg::OFS_TDATA: begin
                  taddr[11:0] <= (taddr[11:0] >= 12'(wave_seq_pkg::LEN_MAX - 12'h001)) ?
                                 12'h000 : 12'(taddr[11:0] + 12'h001);
               end
               default: ;
            endcase
         end
      end
   end

   // sample tick: internal divider or external pin edge
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
         ext_prev <= 1'b0;
      end else if (CLK_EN) begin
         ext_prev <= ext_stable;
         tick <= 1'b0;
         if (!enable) begin
            div_cnt <= 16'h0000;
         end else if (ext_mode) begin
            tick <= ext_stable && !ext_prev;
         end else if (div_cnt >= divider) begin
            div_cnt <= 16'h0000;
            tick <= 1'b1;
         end else begin
            div_cnt <= 16'(div_cnt + 16'h0001);
         end
      end
   end

   // tick capture flop and select sample for the demux
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trig_q <= 1'b0;
         sel_q <= 1'b0;
         src_q <= 1'b0;
         DAC_CODE <= 8'h00;
      end else if (CLK_EN) begin
         trig_q <= tick;
         sel_q <= sel_stable;
         if (trig_q) begin
            src_q <= sel_q;
         end
         DAC_CODE <= src_q ? smp2 : smp1;
      end
   end

   table_channel u_ch1 (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .trig(trig1),
      .restart(restart1),
      .len(len1),
      .start(phase_index(phase1, len1)),
      .wr_en(tw1),
      .wr_idx(taddr[11:0]),
      .wr_data(wr_data[7:0]),
      .rd_idx(taddr[11:0]),
      .rd_data(rd1),
      .sample(smp1),
      .last(last1),
      .idx(idx1)
   );

   table_channel u_ch2 (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .trig(trig2),
      .restart(restart2),
      .len(len2),
      .start(phase_index(phase2, len2)),
      .wr_en(tw2),
      .wr_idx(taddr[11:0]),
      .wr_data(wr_data[7:0]),
      .rd_idx(taddr[11:0]),
      .rd_data(rd2),
      .sample(smp2),
      .last(last2),
      .idx(idx2)
   );

   // completion strobes, sticky status, interrupt; set beats clear
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         last1_d <= 1'b0;
         last2_d <= 1'b0;
         WAVE1_DONE <= 1'b0;
         WAVE2_DONE <= 1'b0;
         status <= 2'h0;
         IRQ <= 1'b0;
      end else if (CLK_EN) begin
         last1_d <= last1;
         last2_d <= last2;
         WAVE1_DONE <= last1 || last1_d;
         WAVE2_DONE <= last2 || last2_d;
         if (wr_fire && wr_addr == wave_seq_pkg::OFS_STAT && wr_strb[0]) begin
            status <= (status & ~wr_data[1:0]) | {last2, last1};
         end else begin
            status <= status | {last2, last1};
         end
         IRQ <= |(status & mask);
      end
   end

   property p_done1;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      last1 ##1 !last1 ##1 !last1 |-> WAVE1_DONE && $past(WAVE1_DONE) ##1 !WAVE1_DONE;
   endproperty
   a_done1: assert property (p_done1) else $error("wave1 done not two cycles");

   property p_done2;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      last2 |=> WAVE2_DONE [*2];
   endproperty
   a_done2: assert property (p_done2) else $error("wave2 done too short");

   property p_route;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      trig_q && sel_q && !restart1 |=> $stable(idx1);
   endproperty
   a_route: assert property (p_route) else $error("table one moved while two selected");

   property p_int_tick;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      enable && !ext_mode && div_cnt == divider && !wr_fire |=> tick && div_cnt == 16'h0000;
   endproperty
   a_int_tick: assert property (p_int_tick) else $error("divider tick missed");

   property p_ext_tick;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      enable && ext_mode && !wr_fire |=> tick == ($past(ext_stable) && !$past(ext_prev));
   endproperty
   a_ext_tick: assert property (p_ext_tick) else $error("external tick wrong");

   property p_len;
      @(posedge CORE_CLK) disable iff (!RESET_N)
      len1 != 12'h000 && len1 <= wave_seq_pkg::LEN_MAX && len2 <= wave_seq_pkg::LEN_MAX;
   endproperty
   a_len: assert property (p_len) else $error("table length out of range");

   property p_sticky;
      @(posedge CORE_CLK) disable iff (!RESET_N || !CLK_EN)
      last1 |=> status[0] ##1 IRQ == mask[0] || status[1] && mask[1];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status or interrupt lost");
endmodule
